// [rtl/power_mode_controller.sv]
// Power mode controller: mode state machine, domain gating, wake routing.
// Assumes an APB master on clk, and that rst_n is the power-on reset.
//
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "pmc_params.svh"
module power_mode_controller #(
	parameter int GPIO_W = 8
) (
	// Clock and reset
	input  wire logic                        clk,
	input  wire logic                        rst_n,
	// APB slave
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [11:0]                 paddr,
	input  wire logic [31:0]                 pwdata,
	output logic                             pready,
	output logic [31:0]                      prdata,
	output logic                             pslverr,
	// Wake and event sources, pin output request
	input  wire logic                        irqEvent,
	input  wire logic                        rtcEvent,
	input  wire logic                        sensorEvent,
	input  wire logic                        resetPinAsync,
	input  wire logic                        debugHaltAsync,
	input  wire logic [GPIO_W-1:0]           gpioIn,
	input  wire logic [GPIO_W-1:0]           gpioOutReq,
	// Domain controls
	output logic                             cpuClockEn,
	output logic                             memClockEn,
	output logic                             periphEn,
	output logic                             alwaysOnDomainPwr,
	output logic                             sensorCtrlPwr,
	output logic                             lowFreqClockEn,
	output logic                             mediumSpeedClockAvail,
	output logic                             highSpeedClockEn,
	output logic                             brownoutDetectorEn,
	output logic                             porEn,
	output logic                             watchdogCounterRun,
	output logic [1:0]                       retainLevel,
	output logic                             sramRetain,
	output logic                             contextRestore,
	output logic                             softReset,
	// Pin latch, mode state and interrupt
	output logic [GPIO_W-1:0]                gpioOut,
	output logic                             gpioLatched,
	output power_mode_pkg::power_mode_t      modeState,
	output logic                             irqOut
);
	import power_mode_pkg::*;

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	logic [GPIO_W+1:0] syncLevel;
	logic [GPIO_W+1:0] syncEdge;
	pin_edge_sync #(.WIDTH(GPIO_W + 2)) u_sync (
		.clk      (clk),
		.rst_n    (rst_n),
		.pinAsync ({debugHaltAsync, resetPinAsync, gpioIn}),
		.pinSync  (syncLevel),
		.pinEdge  (syncEdge)
	);
	wire               resetPinHeld = syncLevel[GPIO_W];
	wire               debugHalt    = syncLevel[GPIO_W+1];
	wire [GPIO_W-1:0]  gpioEdge     = syncEdge[GPIO_W-1:0];

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	power_mode_t                 mode_q;
	power_mode_t                 mode_d;
	logic [1:0]                  req_q;
	logic                        reqPend_q;
	logic [2:0]                  wakeCfg_q;
	reset_cause_t                cause_q;
	logic [`PMC_IRQ_WIDTH-1:0]   irqStat_q;
	logic [`PMC_IRQ_WIDTH-1:0]   irqMask_q;
	logic [GPIO_W-1:0]           shdPins_q;
	logic [GPIO_W-1:0]           pinHold_q;
	logic                        held_q;
	logic [3:0]                  settle_q;
	logic                        wasShutdown_q;

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	// Writes land only at the edge where the master samples pready
	wire wrEn   = psel && penable && pwrite && pready;
	wire rdAcc  = psel && penable && !pwrite;
	wire hitReq = paddr == `PMC_ADDR_MODE_REQ;
	wire hitCfg = paddr == `PMC_ADDR_WAKE_CFG;
	wire hitSt  = paddr == `PMC_ADDR_IRQ_STAT;
	wire hitMsk = paddr == `PMC_ADDR_IRQ_MASK;
	wire hitShd = paddr == `PMC_ADDR_SHD_PINS;
	wire mapped = hitReq || hitCfg || hitSt || hitMsk || hitShd
		|| paddr == `PMC_ADDR_MODE_STAT || paddr == `PMC_ADDR_RST_CAUSE;
	wire [1:0] wrMode = pwdata[1:0];

	// Request only to a lower mode from active is accepted
	wire reqWrite = wrEn && hitReq && mode_q == MODE_ACTIVE && wrMode != MODE_ACTIVE;

	// ----------------------------------------------------------------
	// Wake logic
	// ----------------------------------------------------------------
	wire standbyWake = (wakeCfg_q[`PMC_WAKE_PIN_BIT]  && |gpioEdge)
		|| (wakeCfg_q[`PMC_WAKE_RTC_BIT]  && rtcEvent)
		|| (wakeCfg_q[`PMC_WAKE_SENS_BIT] && sensorEvent);
	wire shutdownWake = |(gpioEdge & shdPins_q);
	wire acceptNow = reqPend_q && settle_q == 4'h0;

	always_comb begin
		mode_d = mode_q;
		unique case (mode_q)
			MODE_ACTIVE:   if (acceptNow) mode_d = power_mode_t'(req_q);
			MODE_IDLE:     if (irqEvent) mode_d = MODE_ACTIVE;
			MODE_STANDBY:  if (standbyWake) mode_d = MODE_ACTIVE;
			MODE_SHUTDOWN: mode_d = MODE_SHUTDOWN;
		endcase
	end

	wire wakeEvt   = (mode_q != MODE_ACTIVE) && (mode_d == MODE_ACTIVE);
	wire [`PMC_IRQ_WIDTH-1:0] irqSet = {acceptNow, wakeEvt};
	wire [`PMC_IRQ_WIDTH-1:0] irqClr = (wrEn && hitSt) ? pwdata[`PMC_IRQ_WIDTH-1:0] : '0;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mode_q        <= MODE_ACTIVE;
			req_q         <= 2'h0;
			reqPend_q     <= 1'b0;
			settle_q      <= 4'h0;
			wakeCfg_q     <= 3'h0;
			irqMask_q     <= '0;
			shdPins_q     <= '0;
			irqStat_q     <= '0;
			held_q        <= 1'b0;
			wasShutdown_q <= 1'b0;
			cause_q       <= `PMC_CAUSE_POR;
		end else if (resetPinHeld || shutdownWake && mode_q == MODE_SHUTDOWN) begin
			// Internal reset: registers cleared, cause and held_q reloaded, pinHold_q kept
			mode_q        <= MODE_ACTIVE;
			req_q         <= 2'h0;
			reqPend_q     <= 1'b0;
			settle_q      <= 4'h0;
			wakeCfg_q     <= 3'h0;
			irqMask_q     <= '0;
			shdPins_q     <= '0;
			irqStat_q     <= '0;
			held_q        <= resetPinHeld;
			wasShutdown_q <= 1'b0;
			cause_q       <= resetPinHeld ? `PMC_CAUSE_PIN_RST : `PMC_CAUSE_SHD_WAKE;
		end else begin
			mode_q    <= mode_d;
			held_q    <= 1'b0;
			if (reqWrite && !reqPend_q) begin
				req_q     <= wrMode;
				reqPend_q <= 1'b1;
				settle_q  <= `PMC_SETTLE_CYCLES;
			end else if (acceptNow) begin
				reqPend_q <= 1'b0;
			end else if (settle_q != 4'h0) begin
				settle_q  <= settle_q - 4'h1;
			end
			if (wrEn && hitCfg) wakeCfg_q <= pwdata[2:0];
			if (wrEn && hitMsk) irqMask_q <= pwdata[`PMC_IRQ_WIDTH-1:0];
			if (wrEn && hitShd) shdPins_q <= pwdata[GPIO_W-1:0];
			// Set beats clear in the same cycle
			irqStat_q <= (irqStat_q & ~irqClr) | irqSet;
			wasShutdown_q <= mode_q == MODE_SHUTDOWN;
		end
	end

	// Pins follow software except while latched
	wire latchPins = mode_q == MODE_STANDBY || mode_q == MODE_SHUTDOWN;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pinHold_q <= '0;
		end else if (!latchPins) begin
			pinHold_q <= gpioOutReq;
		end
	end

	// ----------------------------------------------------------------
	// Domain gating, all registered
	// ----------------------------------------------------------------
	wire isAct  = mode_q == MODE_ACTIVE && !resetPinHeld;
	wire isIdle = mode_q == MODE_IDLE && !resetPinHeld;
	wire isStby = mode_q == MODE_STANDBY && !resetPinHeld;
	wire onAny  = isAct || isIdle || isStby;

	wire [31:0] rdMux =
		(paddr == `PMC_ADDR_MODE_REQ)  ? {30'h0, req_q} :
		(paddr == `PMC_ADDR_MODE_STAT) ? {29'h0, reqPend_q, mode_q} :
		hitCfg                         ? {29'h0, wakeCfg_q} :
		(paddr == `PMC_ADDR_RST_CAUSE) ? {30'h0, cause_q} :
		hitSt                          ? {30'h0, irqStat_q} :
		hitMsk                         ? {30'h0, irqMask_q} :
		hitShd                         ? {{(32-GPIO_W){1'b0}}, shdPins_q} : 32'h0;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cpuClockEn            <= 1'b0;
			memClockEn            <= 1'b0;
			periphEn              <= 1'b0;
			alwaysOnDomainPwr     <= 1'b0;
			sensorCtrlPwr         <= 1'b0;
			lowFreqClockEn        <= 1'b0;
			mediumSpeedClockAvail <= 1'b0;
			highSpeedClockEn      <= 1'b0;
			brownoutDetectorEn    <= 1'b0;
			porEn                 <= 1'b0;
			watchdogCounterRun    <= 1'b0;
			retainLevel           <= 2'h0;
			sramRetain            <= 1'b0;
			contextRestore        <= 1'b0;
			softReset             <= 1'b0;
			gpioOut               <= '0;
			gpioLatched           <= 1'b0;
			modeState             <= MODE_ACTIVE;
			irqOut                <= 1'b0;
			pready                <= 1'b0;
			prdata                <= 32'h0;
			pslverr               <= 1'b0;
		end else begin
			cpuClockEn            <= isAct;
			memClockEn            <= isAct;
			periphEn              <= isAct || isIdle;
			alwaysOnDomainPwr     <= onAny;
			sensorCtrlPwr         <= onAny;
			lowFreqClockEn        <= onAny;
			mediumSpeedClockAvail <= onAny;
			highSpeedClockEn      <= isAct || isIdle;
			brownoutDetectorEn    <= onAny;
			porEn                 <= onAny;
			watchdogCounterRun    <= (isAct || isIdle) && !debugHalt;
			retainLevel           <= (isAct || isIdle) ? 2'h2 : isStby ? 2'h1 : 2'h0;
			sramRetain            <= onAny;
			contextRestore        <= isStby && standbyWake;
			softReset             <= resetPinHeld || (mode_q == MODE_SHUTDOWN && shutdownWake);
			gpioOut               <= latchPins ? pinHold_q : gpioOutReq;
			gpioLatched           <= latchPins;
			modeState             <= mode_q;
			irqOut                <= |(irqStat_q & irqMask_q);
			// One wait state: answer in the access cycle after the first
			pready                <= psel && penable && !pready;
			prdata                <= rdAcc ? rdMux : 32'h0;
			pslverr               <= psel && penable && !pready && !mapped;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_idle_irq_wake: assert property (@(posedge clk) disable iff (!rst_n)
		mode_q == MODE_IDLE && irqEvent && !resetPinHeld |=> mode_q == MODE_ACTIVE)
		else $error("idle did not wake on interrupt");
	a_standby_no_wake: assert property (@(posedge clk) disable iff (!rst_n)
		mode_q == MODE_STANDBY && !standbyWake && !resetPinHeld |=> mode_q == MODE_STANDBY)
		else $error("standby left without wake event");
	a_pin_latch_hold: assert property (@(posedge clk) disable iff (!rst_n)
		gpioLatched && $past(latchPins) && latchPins |=> $stable(gpioOut))
		else $error("latched pins moved");
	a_shut_power_off: assert property (@(posedge clk) disable iff (!rst_n)
		mode_q == MODE_SHUTDOWN ##1 mode_q == MODE_SHUTDOWN |-> !alwaysOnDomainPwr && !sensorCtrlPwr)
		else $error("power left on in shutdown");
	a_shut_pin_wake: assert property (@(posedge clk) disable iff (!rst_n)
		mode_q == MODE_SHUTDOWN && shutdownWake && !resetPinHeld
		|=> mode_q == MODE_ACTIVE && cause_q == `PMC_CAUSE_SHD_WAKE)
		else $error("shutdown pin wake missed");
	a_reset_pin_cause: assert property (@(posedge clk) disable iff (!rst_n)
		resetPinHeld |=> cause_q == `PMC_CAUSE_PIN_RST && !cpuClockEn)
		else $error("reset pin cause wrong");
	a_retain_level: assert property (@(posedge clk) disable iff (!rst_n)
		isStby |=> retainLevel == 2'h1 && sramRetain)
		else $error("standby retention wrong");
	a_watchdog_pause: assert property (@(posedge clk) disable iff (!rst_n)
		mode_q == MODE_STANDBY |=> !watchdogCounterRun)
		else $error("watchdog ran in standby");
	a_accept_gate: assert property (@(posedge clk) disable iff (!rst_n)
		reqWrite && !reqPend_q && !resetPinHeld |=> (mode_q == MODE_ACTIVE) [*3])
		else $error("mode changed before acceptance");
	a_active_run: assert property (@(posedge clk) disable iff (!rst_n)
		mode_q == MODE_ACTIVE && !resetPinHeld |=> cpuClockEn && memClockEn && periphEn)
		else $error("active mode gated a domain");
	a_idle_cpu_off: assert property (@(posedge clk) disable iff (!rst_n)
		mode_q == MODE_IDLE |=> !cpuClockEn && !memClockEn)
		else $error("cpu clocked in idle");
	a_restore_on_wake: assert property (@(posedge clk) disable iff (!rst_n)
		isStby && standbyWake |=> contextRestore && mode_q == MODE_ACTIVE)
		else $error("standby wake did not restore context");
	a_standby_pins_latched: assert property (@(posedge clk) disable iff (!rst_n)
		mode_q == MODE_STANDBY |=> gpioLatched)
		else $error("pins not latched in standby");
	a_shut_stays: assert property (@(posedge clk) disable iff (!rst_n)
		mode_q == MODE_SHUTDOWN && !shutdownWake && !resetPinHeld |=> mode_q == MODE_SHUTDOWN)
		else $error("shutdown left without wake");
	a_shut_clocks_off: assert property (@(posedge clk) disable iff (!rst_n)
		wasShutdown_q |-> !lowFreqClockEn && !mediumSpeedClockAvail && !watchdogCounterRun)
		else $error("clock left running in shutdown");
	a_held_domains_off: assert property (@(posedge clk) disable iff (!rst_n)
		held_q |-> !cpuClockEn && !brownoutDetectorEn && !porEn)
		else $error("domain on while reset pin held");
	a_accept_irq_set: assert property (@(posedge clk) disable iff (!rst_n)
		acceptNow && !resetPinHeld |=> irqStat_q[`PMC_IRQ_ACCEPT_BIT])
		else $error("accepted request not flagged");
endmodule

// [rtl/pmc_params.svh]
// Constants of the power mode controller: offsets, fields, reset values.
// Assumes an APB slave with 32-bit data and word-aligned registers.
`ifndef PMC_PARAMS_SVH
`define PMC_PARAMS_SVH
`define PMC_ADDR_MODE_REQ   12'h000
`define PMC_ADDR_MODE_STAT  12'h004
`define PMC_ADDR_WAKE_CFG   12'h008
`define PMC_ADDR_RST_CAUSE  12'h00c
`define PMC_ADDR_IRQ_STAT   12'h010
`define PMC_ADDR_IRQ_MASK   12'h014
`define PMC_ADDR_SHD_PINS   12'h018
`define PMC_IRQ_WAKE_BIT    0
`define PMC_IRQ_ACCEPT_BIT  1
`define PMC_IRQ_WIDTH       2
`define PMC_CAUSE_POR       2'h0
`define PMC_CAUSE_PIN_RST   2'h1
`define PMC_CAUSE_SHD_WAKE  2'h2
`define PMC_WAKE_PIN_BIT    0
`define PMC_WAKE_RTC_BIT    1
`define PMC_WAKE_SENS_BIT   2
`define PMC_SETTLE_CYCLES   4'h3
`endif

// [rtl/power_mode_pkg.sv]
// Types shared by the power mode controller.
// Assumes the constants header is included where offsets are needed.
package power_mode_pkg;
	typedef enum logic [1:0] {
		MODE_ACTIVE   = 2'b00,
		MODE_IDLE     = 2'b01,
		MODE_STANDBY  = 2'b10,
		MODE_SHUTDOWN = 2'b11
	} power_mode_t;
	typedef logic [1:0] reset_cause_t;
endpackage

// [rtl/pin_edge_sync.sv]
// Two-stage synchroniser plus edge detector for a bank of pins.
// Assumes pins are asynchronous to clk.
`timescale 1ns/1ps
module pin_edge_sync #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// Pins
	input  wire logic [WIDTH-1:0] pinAsync,
	output logic      [WIDTH-1:0] pinSync,
	output logic      [WIDTH-1:0] pinEdge
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] last_q;

	// First stage feeds only the second stage
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_q <= '0;
			sync_q <= '0;
			last_q <= '0;
		end else begin
			meta_q <= pinAsync;
			sync_q <= meta_q;
			last_q <= sync_q;
		end
	end

	assign pinSync = sync_q;
	assign pinEdge = sync_q ^ last_q;
endmodule

// [tb/test_power_mode_controller.sv]
// Self-checking bench for the power mode controller.
// Assumes the design's APB slave and mode walk as handed over.
`timescale 1ns/1ps
`include "pmc_params.svh"
module test_power_mode_controller;
	import power_mode_pkg::*;
	// ----------------------------------------
	// Stimulus and observed signals
	// ----------------------------------------
	logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, rdErr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdData;
	logic        irqEvent, rtcEvent, sensorEvent, resetPinAsync, debugHaltAsync;
	logic [7:0]  gpioIn, gpioOutReq, gpioOut;
	logic        cpuClockEn, memClockEn, periphEn, alwaysOnDomainPwr, sensorCtrlPwr;
	logic        lowFreqClockEn, mediumSpeedClockAvail, highSpeedClockEn;
	logic        brownoutDetectorEn, porEn, watchdogCounterRun, sramRetain;
	logic        contextRestore, softReset, gpioLatched, irqOut, restoreSeen;
	logic [1:0]  retainLevel;
	power_mode_t modeState;
	int          err_total, cmp_count;

	power_mode_controller #(.GPIO_W(8)) DUT (
		.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .irqEvent(irqEvent), .rtcEvent(rtcEvent),
		.sensorEvent(sensorEvent), .resetPinAsync(resetPinAsync),
		.debugHaltAsync(debugHaltAsync), .gpioIn(gpioIn), .gpioOutReq(gpioOutReq),
		.cpuClockEn(cpuClockEn), .memClockEn(memClockEn), .periphEn(periphEn),
		.alwaysOnDomainPwr(alwaysOnDomainPwr), .sensorCtrlPwr(sensorCtrlPwr),
		.lowFreqClockEn(lowFreqClockEn), .mediumSpeedClockAvail(mediumSpeedClockAvail),
		.highSpeedClockEn(highSpeedClockEn), .brownoutDetectorEn(brownoutDetectorEn),
		.porEn(porEn), .watchdogCounterRun(watchdogCounterRun),
		.retainLevel(retainLevel), .sramRetain(sramRetain),
		.contextRestore(contextRestore), .softReset(softReset), .gpioOut(gpioOut),
		.gpioLatched(gpioLatched), .modeState(modeState), .irqOut(irqOut)
	);

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic summarize();
		$display("checks %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			$display("unexpected %s expected %h seen %h", name, exp, got);
			err_total++;
		end
	endtask

	// Read data and error are taken only at the edge where pready is high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rdData = prdata;
		rdErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) begin
			err_total++;
			summarize();
		end
	endtask

	// Domain outputs are registered with modeState, a cycle after the mode; settle two more
	task automatic waitMode(input power_mode_t m);
		int n;
		n = 0;
		while (modeState !== m && n < 60) begin
			@(posedge clk);
			if (contextRestore === 1'b1) restoreSeen = 1'b1;
			n++;
		end
		if (n >= 60) begin
			err_total++;
			summarize();
		end
		repeat (2) @(posedge clk);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic runActive();
		chk("mode", 32'(MODE_ACTIVE), 32'(modeState));
		chk("cpu", 32'hf, 32'({cpuClockEn, memClockEn, periphEn, highSpeedClockEn}));
		chk("retain", 32'h2, 32'(retainLevel));
		apb(1'b0, `PMC_ADDR_RST_CAUSE, 32'h0);
		chk("cause", 32'(`PMC_CAUSE_POR), rdData);
		apb(1'b0, 12'h0f0, 32'h0);
		chk("unmapped", 32'h1, 32'(rdErr));
	endtask

	task automatic runIdle();
		apb(1'b1, `PMC_ADDR_MODE_REQ, 32'h1);
		waitMode(MODE_IDLE);
		chk("idleClk", 32'h1, 32'({cpuClockEn, memClockEn, periphEn}));
		chk("idleWdog", 32'h1, 32'(watchdogCounterRun));
		apb(1'b1, `PMC_ADDR_IRQ_MASK, 32'h2);
		repeat (2) @(posedge clk);
		chk("irqOn", 32'h1, 32'(irqOut));
		apb(1'b1, `PMC_ADDR_IRQ_STAT, 32'h2);
		repeat (2) @(posedge clk);
		chk("irqOff", 32'h0, 32'(irqOut));
		irqEvent <= 1'b1;
		@(posedge clk);
		irqEvent <= 1'b0;
		waitMode(MODE_ACTIVE);
	endtask

	task automatic runStandby();
		gpioOutReq <= 8'h5a;
		apb(1'b1, `PMC_ADDR_IRQ_STAT, 32'h3);
		apb(1'b1, `PMC_ADDR_WAKE_CFG, 32'h2);
		apb(1'b1, `PMC_ADDR_MODE_REQ, 32'h2);
		waitMode(MODE_STANDBY);
		gpioOutReq <= 8'ha5;
		sensorEvent <= 1'b1;
		@(posedge clk);
		sensorEvent <= 1'b0;
		repeat (3) @(posedge clk);
		chk("sbMode", 32'(MODE_STANDBY), 32'(modeState));
		chk("sbDom", 32'h9, 32'({alwaysOnDomainPwr, periphEn, cpuClockEn, sramRetain}));
		chk("sbPins", 32'h15a, 32'({gpioLatched, gpioOut}));
		chk("sbClk", 32'h3, 32'({lowFreqClockEn, mediumSpeedClockAvail}));
		chk("sbWdog", 32'h0, 32'(watchdogCounterRun));
		chk("sbRetain", 32'h1, 32'(retainLevel));
		restoreSeen = 1'b0;
		rtcEvent <= 1'b1;
		@(posedge clk);
		rtcEvent <= 1'b0;
		waitMode(MODE_ACTIVE);
		chk("restore", 32'h1, 32'(restoreSeen));
		apb(1'b0, `PMC_ADDR_IRQ_STAT, 32'h0);
		chk("wakeBit", 32'h1, rdData & 32'h1);
	endtask

	task automatic runShutdown();
		apb(1'b1, `PMC_ADDR_SHD_PINS, 32'h1);
		apb(1'b1, `PMC_ADDR_MODE_REQ, 32'h3);
		waitMode(MODE_SHUTDOWN);
		gpioOutReq <= 8'h3c;
		repeat (2) @(posedge clk);
		chk("sdPwr", 32'h0, 32'({alwaysOnDomainPwr, sensorCtrlPwr, porEn, sramRetain}));
		chk("sdClk", 32'h0, 32'({lowFreqClockEn, brownoutDetectorEn, retainLevel}));
		chk("sdPins", 32'ha5, 32'(gpioOut));
		gpioIn <= 8'h01;
		waitMode(MODE_ACTIVE);
		repeat (8) @(posedge clk);
		apb(1'b0, `PMC_ADDR_RST_CAUSE, 32'h0);
		chk("causeWake", 32'(`PMC_CAUSE_SHD_WAKE), rdData);
		apb(1'b0, `PMC_ADDR_WAKE_CFG, 32'h0);
		chk("cfgLost", 32'h0, rdData);
	endtask

	task automatic runResetPin();
		debugHaltAsync <= 1'b1;
		repeat (6) @(posedge clk);
		chk("dbgWdog", 32'h0, 32'(watchdogCounterRun));
		debugHaltAsync <= 1'b0;
		resetPinAsync <= 1'b1;
		repeat (8) @(posedge clk);
		chk("heldOff", 32'h0, 32'({cpuClockEn, brownoutDetectorEn, porEn, lowFreqClockEn}));
		chk("heldRetain", 32'h0, 32'({retainLevel, sramRetain}));
		chk("softReset", 32'h1, 32'(softReset));
		resetPinAsync <= 1'b0;
		repeat (10) @(posedge clk);
		chk("pinWake", 32'h1, 32'(cpuClockEn));
		apb(1'b0, `PMC_ADDR_RST_CAUSE, 32'h0);
		chk("causePin", 32'(`PMC_CAUSE_PIN_RST), rdData);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		err_total = 0;
		cmp_count = 0;
		rst_n = 1'b0;
		{psel, penable, pwrite, irqEvent, rtcEvent, sensorEvent} = 6'h00;
		{resetPinAsync, debugHaltAsync, restoreSeen} = 3'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		gpioIn = 8'h00;
		gpioOutReq = 8'h00;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		runActive();
		runIdle();
		runStandby();
		runShutdown();
		runResetPin();
		summarize();
	end
endmodule
